// >>> hdl/rwp_pkg.sv
// package: register map, field positions, reset values and timing for the wake polling block
//----------------------------------------------------------------------
// Overview of operation
//----------------------------------------------------------------------
package rwp_pkg;
    // register byte offsets
    localparam logic [11:0] RWP_CTRL_OFF = 12'h000;
    localparam logic [11:0] RWP_SLEEP_OFF = 12'h004;
    localparam logic [11:0] RWP_LISTEN_OFF = 12'h008;
    localparam logic [11:0] RWP_CAL_OFF = 12'h00C;
    localparam logic [11:0] RWP_RSSI_OFF = 12'h010;
    localparam logic [11:0] RWP_STAT_OFF = 12'h014;
    localparam logic [11:0] RWP_STAMP_OFF = 12'h018;
    localparam logic [11:0] RWP_DIV_OFF = 12'h01C;
    // control fields
    localparam int RWP_C_EN = 0;
    localparam int RWP_C_DIV = 1;
    localparam int RWP_C_DIFF = 2;
    localparam int RWP_C_PRE = 3;
    localparam int RWP_C_TCXO = 4;
    localparam int RWP_C_CAL = 5;
    localparam int RWP_C_ACK = 6;
    // reset values
    localparam logic [15:0] RWP_SLEEP_RST = 16'h0020;
    localparam logic [15:0] RWP_LISTEN_RST = 16'h0004;
    localparam logic [15:0] RWP_CAL_RST = 16'h0010;
    localparam logic [7:0] RWP_RSSI_RST = 8'h40;
    // timing
    localparam int RWP_CLK_HZ = 125_000_000;
    localparam int RWP_RC_HZ = 32_000;
    localparam int RWP_RC_DIV = RWP_CLK_HZ / RWP_RC_HZ;
    localparam int RWP_CAL_CYCLES = 4;
    localparam int RWP_ACK_CYCLES = 16;

    typedef enum logic [2:0] {
        RWP_SLEEP,
        RWP_LISTEN,
        RWP_RECEIVE,
        RWP_ACK,
        RWP_CALIB
    } rwp_state_t;
endpackage

// >>> hdl/rwp_tick_if.sv
// interface: slow tick from the rc divider to the polling sequencer
`timescale 1ns/1ps
interface rwp_tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input tick);
endinterface

// >>> hdl/rwp_rc_div.sv
// module: divider making the 32 kHz sleep timer enable
`timescale 1ns/1ps
module rwp_rc_div
    import rwp_pkg::*;
#(
    parameter int DIV = RWP_RC_DIV
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // trim from calibration
    input wire logic [7:0] trim,
    // slow tick
    rwp_tick_if.src tk
);
    initial
    begin
        if (DIV < 8 || DIV > 65000)
            $error("rwp_rc_div: DIV out of range");
    end

    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic [15:0] top;

    // trim nudges the period; calibration only sets it back to the centre value 8'h80
    always_comb
    begin
        top = 16'(DIV - 1) + {8'h00, trim} - 16'h0080;
        cnt_next = (cnt_reg >= top) ? 16'h0000 : cnt_reg + 16'h0001;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_reg <= 16'h0000;
        else
            cnt_reg <= cnt_next;
    end

    assign tk.tick = (cnt_reg >= top);
endmodule

// >>> hdl/rwp_top.sv
// module: enhanced wake polling sequencer with antenna diversity and apb registers
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module rwp_top
    import rwp_pkg::*;
#(
    parameter int RC_DIV = RWP_RC_DIV
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // receiver indications
    input wire logic [7:0] rssi,
    input wire logic preamble_det,
    input wire logic pkt_valid,
    input wire logic pkt_start,
    // radio and oscillator controls
    output logic rx_on,
    output logic tx_on,
    output logic tcxo_en,
    output logic cal_busy,
    // host packet indication
    output logic host_pkt_irq,
    // antenna switch
    output logic ant_sel,
    output logic ant_sel_n
);
    rwp_tick_if tk();
    logic [7:0] trim_reg;
    logic [7:0] trim_next;

    rwp_rc_div #(.DIV(RC_DIV)) u_div (
        .pclk(pclk),
        .presetn(presetn),
        .trim(trim_reg),
        .tk(tk)
    );

    // the divider counts in 16 bits around a trim window of the ratio
    initial
    begin
        if (RC_DIV < 8 || RC_DIV > 65000)
            $error("rwp_top: RC_DIV out of range");
    end

    //------------------------------------------------------------------
    // registers
    //------------------------------------------------------------------
    logic [6:0] ctrl_reg, ctrl_next;
    logic [15:0] sleep_reg, sleep_next;
    logic [15:0] listen_reg, listen_next;
    logic [15:0] cal_reg, cal_next;
    logic [7:0] thr_reg, thr_next;
    logic [15:0] stamp_reg, stamp_next;
    logic pkt_reg, pkt_next;
    logic wr, rd, hit;
    logic pkt_clr;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;

    function automatic logic known(input logic [11:0] a);
        known = (a[1:0] == 2'b00) && (a <= RWP_DIV_OFF);
    endfunction

    assign wr = psel && penable && pwrite;
    assign rd = psel && !pwrite;
    assign hit = known(paddr);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    // only a pkt bit the host has seen is cleared, so a late set is never lost
    assign pkt_clr = psel && penable && !pwrite && (paddr == RWP_STAT_OFF) && prdata_reg[0];

    //------------------------------------------------------------------
    // polling sequencer
    //------------------------------------------------------------------
    rwp_state_t st_reg, st_next;
    logic [15:0] tmr_reg, tmr_next;
    logic [15:0] lst_reg, lst_next;
    logic [15:0] calcnt_reg, calcnt_next;
    logic [4:0] seq_reg, seq_next;
    logic ant_reg, ant_next;
    logic lock_reg, lock_next;
    logic sig_ok;

    assign sig_ok = ctrl_reg[RWP_C_PRE] ? preamble_det : (rssi >= thr_reg);

    always_comb
    begin
        st_next = st_reg;
        tmr_next = tmr_reg;
        lst_next = lst_reg;
        calcnt_next = calcnt_reg;
        seq_next = seq_reg;
        ant_next = ant_reg;
        lock_next = lock_reg;
        stamp_next = stamp_reg;
        trim_next = trim_reg;
        pkt_next = pkt_reg && !pkt_clr;
        if (tk.tick)
            tmr_next = tmr_reg + 16'h0001;
        unique case (st_reg)
            RWP_SLEEP:
            begin
                lock_next = 1'b0;
                if (!ctrl_reg[RWP_C_EN])
                    tmr_next = 16'h0000;
                else if (tk.tick && tmr_reg >= sleep_reg)
                begin
                    if (ctrl_reg[RWP_C_CAL] && calcnt_reg >= cal_reg)
                    begin
                        st_next = RWP_CALIB;
                        seq_next = 5'd0;
                        calcnt_next = 16'h0000;
                    end
                    else
                    begin
                        st_next = RWP_LISTEN;
                        lst_next = 16'h0000;
                        calcnt_next = calcnt_reg + 16'h0001;
                    end
                end
            end
            RWP_CALIB:
            begin
                seq_next = seq_reg + 5'd1;
                if (seq_reg == 5'(RWP_CAL_CYCLES - 1))
                begin
                    trim_next = 8'h80;
                    st_next = RWP_LISTEN;
                    lst_next = 16'h0000;
                end
            end
            RWP_LISTEN:
            begin
                if (tk.tick)
                begin
                    lst_next = lst_reg + 16'h0001;
                    if (ctrl_reg[RWP_C_DIV] && !lock_reg)
                        ant_next = !ant_reg;
                end
                if (ctrl_reg[RWP_C_DIV] && sig_ok)
                    lock_next = 1'b1;
                if (pkt_start)
                begin
                    stamp_next = tmr_reg;
                    st_next = RWP_RECEIVE;
                end
                else if (tk.tick && lst_reg >= listen_reg)
                begin
                    st_next = RWP_SLEEP;
                    tmr_next = 16'h0000;
                end
            end
            RWP_RECEIVE:
            begin
                if (pkt_valid)
                begin
                    pkt_next = 1'b1;
                    st_next = ctrl_reg[RWP_C_ACK] ? RWP_ACK : RWP_SLEEP;
                    seq_next = 5'd0;
                    tmr_next = 16'h0000;
                end
                else if (!sig_ok && tk.tick)
                begin
                    st_next = RWP_SLEEP;
                    tmr_next = 16'h0000;
                end
            end
            RWP_ACK:
            begin
                seq_next = seq_reg + 5'd1;
                if (seq_reg == 5'(RWP_ACK_CYCLES - 1))
                begin
                    st_next = RWP_SLEEP;
                    tmr_next = 16'h0000;
                end
            end
        endcase
    end

    //------------------------------------------------------------------
    // register writes
    //------------------------------------------------------------------
    always_comb
    begin
        ctrl_next = ctrl_reg;
        sleep_next = sleep_reg;
        listen_next = listen_reg;
        cal_next = cal_reg;
        thr_next = thr_reg;
        if (wr)
        begin
            unique case (paddr)
                RWP_CTRL_OFF: ctrl_next = pwdata[6:0];
                RWP_SLEEP_OFF: sleep_next = pwdata[15:0];
                RWP_LISTEN_OFF: listen_next = pwdata[15:0];
                RWP_CAL_OFF: cal_next = pwdata[15:0];
                RWP_RSSI_OFF: thr_next = pwdata[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg <= 7'h00;
            sleep_reg <= RWP_SLEEP_RST;
            listen_reg <= RWP_LISTEN_RST;
            cal_reg <= RWP_CAL_RST;
            thr_reg <= RWP_RSSI_RST;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            sleep_reg <= sleep_next;
            listen_reg <= listen_next;
            cal_reg <= cal_next;
            thr_reg <= thr_next;
        end
    end

    //------------------------------------------------------------------
    // sequencer state
    //------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stamp_reg <= 16'h0000;
            pkt_reg <= 1'b0;
            st_reg <= RWP_SLEEP;
            tmr_reg <= 16'h0000;
            lst_reg <= 16'h0000;
            calcnt_reg <= 16'h0000;
            seq_reg <= 5'd0;
            ant_reg <= 1'b0;
            lock_reg <= 1'b0;
            trim_reg <= 8'h80;
        end
        else
        begin
            stamp_reg <= stamp_next;
            pkt_reg <= pkt_next;
            st_reg <= st_next;
            tmr_reg <= tmr_next;
            lst_reg <= lst_next;
            calcnt_reg <= calcnt_next;
            seq_reg <= seq_next;
            ant_reg <= ant_next;
            lock_reg <= lock_next;
            trim_reg <= trim_next;
        end
    end

    //------------------------------------------------------------------
    // read mux and outputs
    //------------------------------------------------------------------
    // latched in the setup phase so the word stands through the access phase
    always_comb
    begin
        prdata_next = 32'h0000_0000;
        if (rd && !penable)
        begin
            unique case (paddr)
                RWP_CTRL_OFF: prdata_next = {25'h000_0000, ctrl_reg};
                RWP_SLEEP_OFF: prdata_next = {16'h0000, sleep_reg};
                RWP_LISTEN_OFF: prdata_next = {16'h0000, listen_reg};
                RWP_CAL_OFF: prdata_next = {16'h0000, cal_reg};
                RWP_RSSI_OFF: prdata_next = {24'h00_0000, thr_reg};
                RWP_STAT_OFF:
                    prdata_next = {25'h000_0000, lock_reg, ant_reg, 1'b0, st_reg, pkt_reg};
                RWP_STAMP_OFF: prdata_next = {16'h0000, stamp_reg};
                RWP_DIV_OFF: prdata_next = {31'h0000_0000, ant_reg};
                default: prdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_reg <= 32'h0000_0000;
        else
            prdata_reg <= prdata_next;
    end

    assign prdata = prdata_reg;

    assign rx_on = (st_reg == RWP_LISTEN) || (st_reg == RWP_RECEIVE);
    assign tx_on = (st_reg == RWP_ACK);
    assign cal_busy = (st_reg == RWP_CALIB);
    assign tcxo_en = !ctrl_reg[RWP_C_TCXO] || rx_on || tx_on || cal_busy;
    assign host_pkt_irq = pkt_reg;
    assign ant_sel = ctrl_reg[RWP_C_DIV] && ant_reg;
    assign ant_sel_n = ctrl_reg[RWP_C_DIFF] ? !ant_sel : 1'b0;
endmodule

// >>> test/rwp_top_properties.sv
// checker: concurrent properties of the wake polling block
`timescale 1ns/1ps
module rwp_top_properties
(
    // clock, reset, apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // radio side
    input wire logic [7:0] rssi,
    input wire logic preamble_det,
    input wire logic pkt_valid,
    input wire logic pkt_start,
    input wire logic rx_on,
    input wire logic tx_on,
    input wire logic tcxo_en,
    input wire logic cal_busy,
    input wire logic host_pkt_irq,
    input wire logic ant_sel,
    input wire logic ant_sel_n
);
    //----------------------------------------------------------------------
    // properties
    //----------------------------------------------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_cal;
        cal_busy [*4] ##1 !cal_busy;
    endsequence
    property p_cal; $rose(cal_busy) |-> s_cal; endproperty
    property p_tcxo; rx_on |-> tcxo_en; endproperty
    property p_excl; !(rx_on && tx_on) && !(rx_on && cal_busy); endproperty
    property p_diff; ant_sel |-> !ant_sel_n; endproperty
    property p_irq; $rose(host_pkt_irq) |-> $past(pkt_valid); endproperty
    property p_hold; tx_on && $past(tx_on) |-> $stable(ant_sel); endproperty
    property p_acklen; $rose(tx_on) |-> tx_on [*8]; endproperty
    // a write may drop diversity, otherwise only listening moves the switch
    property p_ant; $changed(ant_sel) |-> $past(rx_on) || $past(psel); endproperty
    a_cal: assert property (p_cal) else $error("calibration length wrong");
    a_tcxo: assert property (p_tcxo) else $error("reference off in receive");
    a_excl: assert property (p_excl) else $error("receiver overlaps");
    a_diff: assert property (p_diff) else $error("switch pair not opposite");
    a_irq: assert property (p_irq) else $error("indication without packet");
    a_hold: assert property (p_hold) else $error("switch moved in ack");
    a_acklen: assert property (p_acklen) else $error("ack too short");
    a_ant: assert property (p_ant) else $error("switch moved outside listen");
endmodule
bind rwp_top rwp_top_properties u_props (.*);

// >>> test/rwp_switch_model.sv
// partner: antenna switch with one strong antenna feeding the receiver level
`timescale 1ns/1ps
module rwp_switch_model
(
    // switch control and scene
    input wire logic ant_sel,
    input wire logic sig_on,
    // level seen by the receiver
    output logic [7:0] rssi
);
    // only the high side antenna sees the sender, so diversity has to hunt
    assign rssi = (sig_on && ant_sel) ? 8'hc0 : 8'h10;
endmodule

// >>> test/tb_rwp_top.sv
// testbench: register, polling, diversity and acknowledge scenarios
`timescale 1ns/1ps
module tb_rwp_top;
    import rwp_pkg::*;
    typedef struct {logic [11:0] a; logic [31:0] x; logic e;} rwp_row_t;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic preamble_det = 0, pkt_valid = 0, pkt_start = 0, sig_on = 0, er, prev;
    logic rx_on, tx_on, tcxo_en, cal_busy, host_pkt_irq, ant_sel, ant_sel_n;
    logic [7:0] rssi;
    int mismatches = 0, compares = 0, n = 0;
    rwp_row_t rows [10] = '{'{RWP_CTRL_OFF, 0, 0}, '{RWP_SLEEP_OFF, 32'(RWP_SLEEP_RST), 0},
        '{RWP_LISTEN_OFF, 32'(RWP_LISTEN_RST), 0}, '{RWP_CAL_OFF, 32'(RWP_CAL_RST), 0},
        '{RWP_RSSI_OFF, 32'(RWP_RSSI_RST), 0}, '{RWP_STAT_OFF, 0, 0}, '{RWP_STAMP_OFF, 0, 0},
        '{RWP_DIV_OFF, 0, 0}, '{12'h020, 0, 1}, '{12'h002, 0, 1}};
    rwp_top #(.RC_DIV(16)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rssi(rssi),
        .preamble_det(preamble_det), .pkt_valid(pkt_valid), .pkt_start(pkt_start),
        .rx_on(rx_on), .tx_on(tx_on), .tcxo_en(tcxo_en), .cal_busy(cal_busy),
        .host_pkt_irq(host_pkt_irq), .ant_sel(ant_sel), .ant_sel_n(ant_sel_n));
    rwp_switch_model sw (.ant_sel(ant_sel), .sig_on(sig_on), .rssi(rssi));
    always #4 pclk = ~pclk;
    //----------------------------------------------------------------------
    // tasks
    //----------------------------------------------------------------------
    task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        compares++;
        if (s !== x)
        begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", nm, x, s);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task report_and_stop;
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        #200000;
        mismatches++;
        report_and_stop;
    end
    //----------------------------------------------------------------------
    // scenarios
    //----------------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1;
        chk("rx_on", rx_on, 0);
        chk("tcxo_en", tcxo_en, 1);
        foreach (rows[k])
        begin
            apb(0, rows[k].a, 0);
            chk("rdata", rd, rows[k].x);
            chk("slverr", er, rows[k].e);
            chk("pready", pready, 1);
        end
        apb(1, RWP_SLEEP_OFF, 2);
        apb(1, RWP_LISTEN_OFF, 8);
        apb(0, RWP_SLEEP_OFF, 0);
        chk("sleep", rd, 2);
        apb(1, RWP_CTRL_OFF, 32'h0000_0057);
        repeat (2) @(negedge pclk);
        chk("tcxo_sleep", tcxo_en, 0);
        wait (rx_on === 1);
        prev = ant_sel;
        while (rx_on === 1)
        begin
            @(negedge pclk);
            n += int'(ant_sel !== prev);
            prev = ant_sel;
            chk("ant_n", ant_sel_n, !ant_sel);
        end
        chk("toggles", n > 1, 1);
        wait (rx_on === 1);
        sig_on <= 1;
        wait (ant_sel === 1);
        repeat (48) @(negedge pclk);
        chk("ant_held", ant_sel, 1);
        @(posedge pclk) pkt_start <= 1;
        @(posedge pclk) pkt_start <= 0;
        pkt_valid <= 1;
        @(posedge pclk) pkt_valid <= 0;
        @(negedge pclk);
        chk("irq", host_pkt_irq, 1);
        chk("tx_on", tx_on, 1);
        chk("ant_ack", ant_sel, 1);
        apb(0, RWP_STAT_OFF, 0);
        chk("stat_pkt", rd[0], 1);
        chk("stat_lock", rd[6], 1);
        apb(0, RWP_STAMP_OFF, 0);
        chk("stamp", rd >= 2, 1);
        @(negedge pclk);
        chk("irq_clr", host_pkt_irq, 0);
        apb(1, RWP_CTRL_OFF, 32'h0000_005f);
        sig_on <= 0;
        preamble_det <= 1;
        wait (rx_on === 0);
        wait (rx_on === 1);
        repeat (20) @(negedge pclk);
        apb(0, RWP_STAT_OFF, 0);
        chk("pre_lock", rd[6], 1);
        preamble_det <= 0;
        apb(1, RWP_CAL_OFF, 0);
        apb(1, RWP_CTRL_OFF, 32'h0000_0021);
        wait (cal_busy === 1);
        chk("cal_rx", rx_on, 0);
        repeat (8) @(negedge pclk);
        chk("cal_end", cal_busy, 0);
        chk("cal_listen", rx_on, 1);
        @(posedge pclk);
        presetn <= 0;
        @(posedge pclk);
        presetn <= 1;
        chk("rst_rx", rx_on, 0);
        chk("rst_tcxo", tcxo_en, 1);
        apb(0, RWP_CAL_OFF, 0);
        chk("rst_cal", rd, 32'(RWP_CAL_RST));
        report_and_stop;
    end
endmodule
